// [cfwd_pkg.sv]
// Purpose: constants shared by the forwarding control block
// Assumes: apb byte address is four times the register index
// Notes: all offsets below are register indexes
package cfwd_pkg;
  // ----------------------------------------------------------------
  // register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MAX_HI = 8'h1d;
  localparam logic [7:0] IDX_MAX_LO = 8'h1e;
  localparam logic [7:0] IDX_RATE = 8'h1f;
  localparam logic [7:0] IDX_BLOCK = 8'h20;
  localparam logic [7:0] IDX_MODE = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  localparam logic [7:0] IDX_IRQ_STS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  // ----------------------------------------------------------------
  // reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MAX_HI = 8'h00;
  localparam logic [7:0] RST_MAX_LO = 8'h04;
  localparam logic [7:0] RST_RATE = 8'h02;
  localparam logic [7:0] RST_BLOCK = 8'h30;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] WMASK_RATE = 8'h0f;
  localparam logic [7:0] WMASK_BLOCK = 8'hf0;
  localparam logic [7:0] WMASK_MODE = 8'hcf;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RATE_LSB = 0;
  localparam int P0_BLOCK_BIT = 4;
  localparam int RR_BIT = 0;
  localparam int SYNC_LSB = 2;
  localparam int AS_AVAIL_BIT = 6;
  localparam int REPLICATE_BIT = 7;
  localparam int STS_ALIGNED_BIT = 0;
  localparam int STS_LOST_BIT = 2;
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_1G6 = 2'h0;
  localparam logic [1:0] RATE_800M = 2'h2;
  localparam logic [1:0] RATE_400M = 2'h3;
  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_BASIC = 2'b01,
    SYNC_INTERLEAVE = 2'b10,
    SYNC_CONCAT = 2'b11
  } cfwd_sync_t;
  typedef enum logic [0:0] {
    FW_IDLE = 1'b0,
    FW_SEND = 1'b1
  } cfwd_state_t;
endpackage

// [cfwd_frame_counter.sv]
// Purpose: frame number for raw-mode frame boundary packets
// Assumes: advance is a one-cycle pulse at each frame start
// Notes: zero limit means numbering off
`timescale 1ns/100ps
module cfwd_frame_counter #(
  parameter int W = 16 // frame number width
) (
  input wire logic pclk, // block clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] max_count, // frame limit
  input wire logic advance, // frame start pulse
  output logic [W-1:0] frame_number // current number
);
  logic [W-1:0] next_frame_number;

  always_comb begin
    next_frame_number = frame_number;
    if (max_count == '0) begin
      next_frame_number = '0;
    end else if (advance) begin
      if (frame_number >= max_count || frame_number == '0) begin
        next_frame_number = W'(1);
      end else begin
        next_frame_number = frame_number + W'(1);
      end
    end else if (frame_number > max_count) begin
      // limit dropped below us: next frame starts again at 1
      next_frame_number = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_number <= '0;
    end else begin
      frame_number <= next_frame_number;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence adv_at_limit_s;
    advance && max_count != '0 && frame_number == max_count;
  endsequence

  frame_zero_a: assert property (max_count == '0 |=> frame_number == '0)
    else $error("numbering off but frame number not zero");
  frame_wrap_a: assert property (adv_at_limit_s |=> frame_number == W'(1))
    else $error("frame number did not wrap to one");
  frame_step_a: assert property (advance && frame_number != '0 && frame_number < max_count
    |=> frame_number == $past(frame_number) + W'(1))
    else $error("frame number did not step by one");
  frame_restart_a: assert property (!advance && max_count != '0 && frame_number > max_count
    |=> frame_number == '0)
    else $error("frame number not restarted after limit drop");
endmodule

// [cfwd_forward.sv]
// Purpose: register bank and forwarding control for the csi-2 merge stage
// Assumes: rx and tx strobes are on pclk; link pins are asynchronous
// Notes: apb slave answers with no wait states
// How it works
// - raw mode frames carry a 16-bit number on start and end packets
// - a zero frame limit forces frame number zero
// - nonzero limit: number counts 1 up to limit, then back to 1
// - limit is upper byte register and lower byte register, lower resets 4
// - two-bit rate select: 00 1.6G, 10 800M, 11 400M, reset 800M
// - a set block bit stops that port; both blocked after reset
// - replicate mode copies output 0 onto output 1
// - synchronized mode waits for lines from all enabled ports
// - as-available sends each port's line as soon as ready
// - as-available ignored in concatenation and for frame sync packets
// - two-bit field picks off, basic, interleave or concatenation
// - round robin, on at reset, rotates between ready ports
// - aligned status bit reads zero whenever synchronized mode is off
// - align-lost flag, clear on read, only after one aligned frame
`timescale 1ns/100ps
module cfwd_forward #(
  parameter int NUM_W = 16, // frame number width
  parameter int DATA_W = 32 // csi word width
) (
  input wire logic pclk, // block clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [9:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  input wire logic link_clk, // raw link clock pin
  input wire logic link_frame, // raw link frame pin
  input wire logic [1:0] rx_line_ready, // line waiting per port
  input wire logic [1:0] rx_frame_start, // frame start per port
  input wire logic tx_done, // transmitter finished a line
  input wire logic [DATA_W-1:0] csi0_data, // output 0 word
  input wire logic csi0_valid, // output 0 word valid
  output logic [1:0] fwd_grant, // send line from port
  output logic fwd_concat, // join granted lines
  output logic raw_fs, // emit frame start packet
  output logic raw_fe, // emit frame end packet
  output logic [NUM_W-1:0] frame_number, // number for raw packets
  output logic [1:0] tx_rate_sel, // serial rate code
  output logic [DATA_W-1:0] csi1_data, // output 1 word
  output logic csi1_valid, // output 1 word valid
  output logic irq // interrupt, active high
);
  // ----------------------------------------------------------------
  // apb register bank
  // ----------------------------------------------------------------
  logic [7:0] max_hi, max_lo, rate_reg, block_reg, mode_reg, irq_sts, irq_mask;
  logic [7:0] next_max_hi, next_max_lo, next_rate_reg, next_block_reg, next_mode_reg;
  logic [7:0] next_irq_sts, next_irq_mask, rd_byte;
  logic [31:0] next_prdata;
  logic [7:0] idx;
  logic mapped, wr_en, rd_access;
  logic lost_flag, next_lost_flag, aligned, next_aligned;
  logic lost_evt, frame_evt;

  assign idx = paddr[9:2];
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_access = psel && penable && !pwrite && mapped;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = paddr[1:0] == 2'h0;
    case (idx)
      cfwd_pkg::IDX_MAX_HI: rd_byte = max_hi;
      cfwd_pkg::IDX_MAX_LO: rd_byte = max_lo;
      cfwd_pkg::IDX_RATE: rd_byte = rate_reg;
      cfwd_pkg::IDX_BLOCK: rd_byte = block_reg;
      cfwd_pkg::IDX_MODE: rd_byte = mode_reg;
      cfwd_pkg::IDX_STATUS: begin
        rd_byte = 8'h00;
        rd_byte[cfwd_pkg::STS_ALIGNED_BIT] = aligned;
        rd_byte[cfwd_pkg::STS_LOST_BIT] = lost_flag;
      end
      cfwd_pkg::IDX_IRQ_STS: rd_byte = irq_sts;
      cfwd_pkg::IDX_IRQ_MASK: rd_byte = irq_mask;
      default: begin
        rd_byte = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_max_hi = max_hi;
    next_max_lo = max_lo;
    next_rate_reg = rate_reg;
    next_block_reg = block_reg;
    next_mode_reg = mode_reg;
    next_irq_mask = irq_mask;
    next_irq_sts = irq_sts;
    next_prdata = prdata;
    // data is latched in the setup cycle so it is steady in the access cycle
    if (psel && !penable && !pwrite) begin
      next_prdata = {24'h0, rd_byte};
    end
    if (wr_en) begin
      case (idx)
        cfwd_pkg::IDX_MAX_HI: next_max_hi = pwdata[7:0];
        cfwd_pkg::IDX_MAX_LO: next_max_lo = pwdata[7:0];
        cfwd_pkg::IDX_RATE: next_rate_reg = pwdata[7:0] & cfwd_pkg::WMASK_RATE;
        cfwd_pkg::IDX_BLOCK: next_block_reg = pwdata[7:0] & cfwd_pkg::WMASK_BLOCK;
        cfwd_pkg::IDX_MODE: next_mode_reg = pwdata[7:0] & cfwd_pkg::WMASK_MODE;
        cfwd_pkg::IDX_IRQ_STS: next_irq_sts = irq_sts & ~pwdata[7:0];
        cfwd_pkg::IDX_IRQ_MASK: next_irq_mask = pwdata[7:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // events set after the clear so a same-cycle event survives
    if (frame_evt) begin
      next_irq_sts[cfwd_pkg::IRQ_FRAME_BIT] = 1'b1;
    end
    if (lost_evt) begin
      next_irq_sts[cfwd_pkg::IRQ_LOST_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_hi <= cfwd_pkg::RST_MAX_HI;
      max_lo <= cfwd_pkg::RST_MAX_LO;
      rate_reg <= cfwd_pkg::RST_RATE;
      block_reg <= cfwd_pkg::RST_BLOCK;
      mode_reg <= cfwd_pkg::RST_MODE;
      irq_sts <= 8'h00;
      irq_mask <= 8'h00;
      prdata <= 32'h0;
    end else begin
      max_hi <= next_max_hi;
      max_lo <= next_max_lo;
      rate_reg <= next_rate_reg;
      block_reg <= next_block_reg;
      mode_reg <= next_mode_reg;
      irq_sts <= next_irq_sts;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
    end
  end

  assign irq = |(irq_sts & irq_mask);
  assign tx_rate_sel = rate_reg[cfwd_pkg::RATE_LSB +: 2];

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  logic [1:0] enabled, ready_en;
  logic rr_on, as_avail, replicate;
  cfwd_pkg::cfwd_sync_t sync_mode;

  assign enabled = ~block_reg[cfwd_pkg::P0_BLOCK_BIT +: 2];
  assign ready_en = rx_line_ready & enabled;
  assign rr_on = mode_reg[cfwd_pkg::RR_BIT];
  assign sync_mode = cfwd_pkg::cfwd_sync_t'(mode_reg[cfwd_pkg::SYNC_LSB +: 2]);
  // concatenation needs whole sets of lines, so early sending is off there
  assign as_avail = mode_reg[cfwd_pkg::AS_AVAIL_BIT] && sync_mode != cfwd_pkg::SYNC_CONCAT;
  assign replicate = mode_reg[cfwd_pkg::REPLICATE_BIT];

  // ----------------------------------------------------------------
  // line forwarding engine
  // ----------------------------------------------------------------
  cfwd_pkg::cfwd_state_t state, next_state;
  logic last_port, next_last_port;
  logic [1:0] next_fwd_grant, pick_one;
  logic next_fwd_concat;

  always_comb begin
    // rotate: when both wait, the port not served last goes first
    if (ready_en == 2'b11) begin
      pick_one = last_port ? 2'b01 : 2'b10;
    end else begin
      pick_one = ready_en;
    end
    next_state = state;
    next_last_port = last_port;
    next_fwd_grant = 2'b00;
    next_fwd_concat = fwd_concat;
    case (state)
      cfwd_pkg::FW_IDLE: begin
        if (sync_mode != cfwd_pkg::SYNC_OFF) begin
          if (as_avail) begin
            next_fwd_grant = pick_one;
          end else if (enabled != 2'b00 && ready_en == enabled) begin
            next_fwd_grant = enabled;
          end
          next_fwd_concat = sync_mode == cfwd_pkg::SYNC_CONCAT;
        end else if (rr_on) begin
          next_fwd_grant = pick_one;
          next_fwd_concat = 1'b0;
        end
        if (next_fwd_grant != 2'b00) begin
          next_state = cfwd_pkg::FW_SEND;
          next_last_port = next_fwd_grant[1];
        end
      end
      cfwd_pkg::FW_SEND: begin
        if (tx_done) begin
          next_state = cfwd_pkg::FW_IDLE;
        end
      end
      default: next_state = cfwd_pkg::FW_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cfwd_pkg::FW_IDLE;
      last_port <= 1'b1;
      fwd_grant <= 2'b00;
      fwd_concat <= 1'b0;
    end else begin
      state <= next_state;
      last_port <= next_last_port;
      fwd_grant <= next_fwd_grant;
      fwd_concat <= next_fwd_concat;
    end
  end

  // ----------------------------------------------------------------
  // frame alignment tracking
  // ----------------------------------------------------------------
  // frame starts are sync packets: as-available never touches them
  logic [1:0] seen, next_seen, starts;
  logic sent_one, next_sent_one;

  assign starts = rx_frame_start & enabled;

  always_comb begin
    next_seen = seen;
    next_aligned = aligned;
    next_sent_one = sent_one;
    next_lost_flag = lost_flag;
    lost_evt = 1'b0;
    if (rd_access && idx == cfwd_pkg::IDX_STATUS) begin
      next_lost_flag = 1'b0;
    end
    if (sync_mode == cfwd_pkg::SYNC_OFF) begin
      next_seen = 2'b00;
      next_aligned = 1'b0;
    end else if (starts != 2'b00) begin
      if ((seen & starts) != 2'b00) begin
        next_seen = starts;
        next_aligned = 1'b0;
        lost_evt = sent_one;
      end else if ((seen | starts) == enabled) begin
        next_seen = 2'b00;
        next_aligned = 1'b1;
        next_sent_one = 1'b1;
      end else begin
        next_seen = seen | starts;
      end
    end
    if (lost_evt) begin
      next_lost_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 2'b00;
      aligned <= 1'b0;
      sent_one <= 1'b0;
      lost_flag <= 1'b0;
    end else begin
      seen <= next_seen;
      aligned <= next_aligned;
      sent_one <= next_sent_one;
      lost_flag <= next_lost_flag;
    end
  end

  // ----------------------------------------------------------------
  // raw link pins and frame numbering
  // ----------------------------------------------------------------
  logic [2:0] pin_sync [2];
  logic [1:0] pin_level, next_pin_level;
  logic link_frame_q, next_link_frame_q;
  logic link_rise;

  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_sync[p] <= 3'h0;
      end else begin
        pin_sync[p] <= {pin_sync[p][1:0], p == 0 ? link_clk : link_frame};
      end
    end
    // the level moves only once the second and third stages agree
    assign next_pin_level[p] = pin_sync[p][1] == pin_sync[p][2] ? pin_sync[p][2] : pin_level[p];
  end

  assign link_rise = next_pin_level[0] && !pin_level[0];

  always_comb begin
    next_link_frame_q = link_rise ? pin_level[1] : link_frame_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= 2'b00;
      link_frame_q <= 1'b0;
      raw_fs <= 1'b0;
      raw_fe <= 1'b0;
    end else begin
      pin_level <= next_pin_level;
      link_frame_q <= next_link_frame_q;
      raw_fs <= next_link_frame_q && !link_frame_q;
      raw_fe <= !next_link_frame_q && link_frame_q;
    end
  end

  assign frame_evt = raw_fe;

  cfwd_frame_counter #(.W(NUM_W)) u_count (
    .pclk(pclk),
    .presetn(presetn),
    .max_count(NUM_W'({max_hi, max_lo})),
    .advance(next_link_frame_q && !link_frame_q),
    .frame_number(frame_number)
  );

  // ----------------------------------------------------------------
  // replicate output
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csi1_data <= '0;
      csi1_valid <= 1'b0;
    end else begin
      csi1_data <= replicate ? csi0_data : '0;
      csi1_valid <= replicate && csi0_valid;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rate_write_s;
    wr_en && idx == cfwd_pkg::IDX_RATE;
  endsequence

  block_gate_a: assert property (fwd_grant != 2'b00 |-> ($past(ready_en) & fwd_grant) == fwd_grant)
    else $error("grant to a blocked or idle port");
  wait_all_a: assert property (fwd_grant != 2'b00 && $past(sync_mode != cfwd_pkg::SYNC_OFF && !as_avail)
    |-> fwd_grant == $past(enabled))
    else $error("synchronized grant before all ports ready");
  replicate_a: assert property (replicate && csi0_valid |=> csi1_valid && csi1_data == $past(csi0_data))
    else $error("output 1 does not copy output 0");
  status_off_a: assert property (sync_mode == cfwd_pkg::SYNC_OFF |=> !aligned)
    else $error("aligned status set with sync off");
  rate_out_a: assert property (rate_write_s |=> tx_rate_sel == $past(pwdata[1:0]))
    else $error("rate select not taken from write");
  lost_cause_a: assert property ($rose(lost_flag) |-> $past(sent_one))
    else $error("align lost flagged before any aligned frame");
endmodule

// [cfwd_sink_model.sv]
// Purpose: stand-in for the transmitter and downstream processor
// Assumes: fwd_grant is a one-cycle pulse
// Notes: stall stretches each line so slow sinks are exercised
`timescale 1ns/100ps
module cfwd_sink_model (
  input wire logic pclk, // block clock
  input wire logic presetn, // async reset, active low
  input wire logic [1:0] fwd_grant, // line grant
  input wire logic [3:0] stall, // extra cycles per line
  output logic tx_done // line sent pulse
);
  logic [4:0] cnt;
  logic busy;
  // one line in flight; a grant while busy is simply restarted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (fwd_grant != 2'b00) begin
        busy <= 1'b1;
        cnt <= {1'b0, stall};
      end else if (busy && cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end else if (busy) begin
        busy <= 1'b0;
        tx_done <= 1'b1;
      end
    end
  end
endmodule

// [cfwd_forward_tb.sv]
// Purpose: self-checking bench for the forwarding control block
// Assumes: apb slave answers in its own time; bench waits for pready
// Notes: link clock runs only in raw_frame: three ticks inside each frame, three after it
`timescale 1ns/100ps
module cfwd_forward_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, a;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, csi0_data, csi1_data, rd;
  logic link_clk, link_frame, tx_done, csi0_valid, csi1_valid, fwd_concat, raw_fs, raw_fe, irq;
  logic [1:0] rx_line_ready, rx_frame_start, fwd_grant, tx_rate_sel;
  logic [15:0] frame_number, fs_num, fe_num;
  logic [3:0] stall;
  logic [2:0] glog[$];
  int failures = 0;
  int checked = 0;
  int fs_cnt = 0;
  int fe_cnt = 0;

  cfwd_forward DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link_clk(link_clk), .link_frame(link_frame), .rx_line_ready(rx_line_ready),
    .rx_frame_start(rx_frame_start), .tx_done(tx_done), .csi0_data(csi0_data), .csi0_valid(csi0_valid),
    .fwd_grant(fwd_grant), .fwd_concat(fwd_concat), .raw_fs(raw_fs), .raw_fe(raw_fe),
    .frame_number(frame_number), .tx_rate_sel(tx_rate_sel), .csi1_data(csi1_data),
    .csi1_valid(csi1_valid), .irq(irq));
  cfwd_sink_model SINK (.pclk(pclk), .presetn(presetn), .fwd_grant(fwd_grant), .stall(stall),
    .tx_done(tx_done));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // grants are logged with the concat flag on top
  always @(posedge pclk) begin
    if (fwd_grant !== 2'b00) glog.push_back({fwd_concat, fwd_grant});
    if (raw_fs === 1'b1) fs_cnt++;
    if (raw_fs === 1'b1) fs_num = frame_number;
    if (raw_fe === 1'b1) fe_cnt++;
    if (raw_fe === 1'b1) fe_num = frame_number;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      $display("Error at %0t: no pready from slave", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
  endtask
  task automatic raw_frame(input logic [15:0] exp);
    int f0;
    f0 = fs_cnt;
    // fractional offset keeps every link edge off the pclk edges
    #31.3 link_frame = 1'b1;
    ticks(3);
    link_frame = 1'b0;
    ticks(3);
    repeat (8) @(posedge pclk);
    chk(fs_cnt - f0, 32'h1);
    chk(fe_cnt, fs_cnt);
    chk({16'h0, fs_num}, {16'h0, exp});
    chk({16'h0, fe_num}, {16'h0, exp});
  endtask
  task automatic pulse(input logic [1:0] p);
    @(posedge pclk);
    rx_frame_start <= p;
    @(posedge pclk);
    rx_frame_start <= 2'b00;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] exp[5];
    logic [1:0] codes[3];
    exp = '{8'h00, 8'h04, 8'h02, 8'h30, 8'h01};
    codes = '{2'h0, 2'h3, 2'h2};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'h1d + i[7:0], 8'h00);
      chk(rd, {24'h0, exp[i]});
    end
    apb(1'b0, 8'h25, 8'h00);
    chk({31'h0, err}, 32'h1);
    foreach (codes[i]) begin
      apb(1'b1, 8'h1f, {6'h00, codes[i]});
      repeat (2) @(posedge pclk);
      chk({30'h0, tx_rate_sel}, {30'h0, codes[i]});
    end
    apb(1'b1, 8'h1f, 8'hf2);
    apb(1'b0, 8'h1f, 8'h00);
    chk(rd, 32'h02);
  endtask
  task automatic t_raw;
    apb(1'b1, 8'h1e, 8'h02);
    raw_frame(16'h1);
    raw_frame(16'h2);
    raw_frame(16'h1);
    apb(1'b1, 8'h1e, 8'h00);
    raw_frame(16'h0);
    apb(1'b1, 8'h1e, 8'h03);
    raw_frame(16'h1);
    raw_frame(16'h2);
    apb(1'b1, 8'h1e, 8'h01);
    raw_frame(16'h1);
    apb(1'b0, 8'h30, 8'h00);
    chk(rd & 32'h1, 32'h1);
  endtask
  task automatic t_fwd(input logic [7:0] mode, input logic [7:0] blk, input logic [1:0] rdy,
                       input logic [2:0] e0, input logic [2:0] e1);
    apb(1'b1, 8'h21, mode);
    apb(1'b1, 8'h20, blk);
    @(posedge pclk);
    glog.delete();
    rx_line_ready <= rdy;
    repeat (30) @(posedge pclk);
    rx_line_ready <= 2'b00;
    repeat (20) @(posedge pclk);
    chk({29'h0, (glog.size() > 0) ? glog[0] : 3'h0}, {29'h0, e0});
    chk({29'h0, (glog.size() > 1) ? glog[1] : 3'h0}, {29'h0, e1});
  endtask
  task automatic t_repl;
    apb(1'b1, 8'h21, 8'h81); // replicate only with one- or two-lane outputs, no lane control here
    @(posedge pclk);
    csi0_data <= 32'h5a5a00c3;
    csi0_valid <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(csi1_data, 32'h5a5a00c3);
    chk({31'h0, csi1_valid}, 32'h1);
    apb(1'b1, 8'h21, 8'h01);
    repeat (2) @(posedge pclk);
    chk({31'h0, csi1_valid}, 32'h0);
    csi0_valid <= 1'b0;
  endtask
  task automatic t_sync;
    apb(1'b1, 8'h21, 8'h04);
    apb(1'b1, 8'h20, 8'h00);
    pulse(2'b01);
    pulse(2'b01);
    apb(1'b0, 8'h22, 8'h00);
    chk(rd, 32'h00);
    pulse(2'b10);
    apb(1'b0, 8'h22, 8'h00);
    chk(rd, 32'h01);
    pulse(2'b01);
    pulse(2'b01);
    apb(1'b0, 8'h22, 8'h00);
    chk(rd, 32'h04);
    apb(1'b0, 8'h22, 8'h00);
    chk(rd, 32'h00);
    apb(1'b0, 8'h30, 8'h00);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, 8'h31, 8'h00);
    // the mask write lands at the access edge, so look one edge later
    @(posedge pclk);
    a = irq;
    apb(1'b1, 8'h31, 8'hff);
    @(posedge pclk);
    chk({31'h0, a ^ irq}, 32'h1);
    apb(1'b1, 8'h30, 8'hff);
    apb(1'b0, 8'h30, 8'h00);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    pulse(2'b01);
    pulse(2'b10);
    apb(1'b1, 8'h21, 8'h01);
    apb(1'b0, 8'h22, 8'h00);
    chk(rd & 32'h1, 32'h0);
  endtask
  task automatic final_report;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, link_clk, link_frame, csi0_valid} = 7'h00;
    {paddr, pwdata, csi0_data} = 74'h0;
    {rx_line_ready, rx_frame_start} = 4'h0;
    stall = 4'h4;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_raw();
    t_fwd(8'h01, 8'h30, 2'b11, 3'b000, 3'b000);
    t_fwd(8'h01, 8'h00, 2'b11, 3'b001, 3'b010);
    t_fwd(8'h01, 8'h20, 2'b11, 3'b001, 3'b001);
    t_fwd(8'h04, 8'h00, 2'b01, 3'b000, 3'b000);
    t_fwd(8'h04, 8'h00, 2'b11, 3'b011, 3'b011);
    t_fwd(8'h08, 8'h00, 2'b11, 3'b011, 3'b011);
    t_fwd(8'h0c, 8'h00, 2'b11, 3'b111, 3'b111);
    stall <= 4'h0;
    t_fwd(8'h44, 8'h00, 2'b01, 3'b001, 3'b001);
    t_fwd(8'h4c, 8'h00, 2'b01, 3'b000, 3'b000);
    t_repl();
    t_sync();
    final_report();
  end
endmodule
